// File: host_bus_model.sv
/* Host processor on the parallel register bus.
   Assumes the caller waits for reset; pins change at falling edges. */
`timescale 1ns/10ps
module host_bus_model (
	input wire logic ref_clk_i,
	input wire logic [7:0] rdata_i,
	output logic cs_n_o,
	output logic rd_n_o,
	output logic wr_n_o,
	output logic [2:0] addr_o,
	output logic [7:0] wdata_o
);
	// Idle bus at time zero
	initial begin
		cs_n_o = 1'b1;
		rd_n_o = 1'b1;
		wr_n_o = 1'b1;
		addr_o = 3'h0;
		wdata_o = 8'h00;
	end
	// One access: setup two clocks, strobe five, recovery three
	task automatic access(input logic wr, input logic [2:0] a,
			input logic [7:0] d, output logic [7:0] q);
		@(negedge ref_clk_i);
		addr_o = a;
		wdata_o = d;
		repeat (2) @(negedge ref_clk_i);
		cs_n_o = 1'b0;
		wr_n_o = !wr;
		rd_n_o = wr;
		repeat (5) @(posedge ref_clk_i);
		q = rdata_i;
		@(negedge ref_clk_i);
		cs_n_o = 1'b1;
		wr_n_o = 1'b1;
		rd_n_o = 1'b1;
		wdata_o = ~d; // Released bus shows no stale value
		repeat (3) @(negedge ref_clk_i);
	endtask
endmodule // host_bus_model

// File: sync_fifo.sv
/*
 * First-in first-out buffer with registered flags and registered head data.
 * Assumes one clock; flush and single-entry limit come from the same domain.
 */
`timescale 1ns/10ps
module sync_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int CW = $clog2(DEPTH + 1)
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic flush_i,
	input wire logic single_i,
	input wire logic in_valid_i,
	input wire logic [WIDTH-1:0] in_data_i,
	output logic in_ready_o,
	output logic out_valid_o,
	output logic [WIDTH-1:0] out_data_o,
	input wire logic out_ready_i,
	output logic [CW-1:0] count_o
);
	localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PW-1:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
	logic [CW-1:0] next_count, limit;
	logic next_in_ready, next_out_valid, push, pop;
	logic [WIDTH-1:0] next_out_data;

	// Pointer, count and flag updates
	always_comb begin
		push = in_valid_i & in_ready_o;
		pop = out_ready_i & out_valid_o;
		limit = single_i ? CW'(1) : CW'(DEPTH);
		next_wr_ptr = wr_ptr;
		next_rd_ptr = rd_ptr;
		if (push) begin
			next_wr_ptr = (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
		end
		if (pop) begin
			next_rd_ptr = (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
		end
		next_count = count_o + CW'(push) - CW'(pop);
		if (flush_i) begin
			next_wr_ptr = '0;
			next_rd_ptr = '0;
			next_count = '0;
		end
		next_in_ready = next_count < limit;
		next_out_valid = next_count != '0;
		// Bypass when the new word lands straight at the head
		if (push && !flush_i && wr_ptr == next_rd_ptr) begin
			next_out_data = in_data_i;
		end else begin
			next_out_data = mem[next_rd_ptr];
		end
	end

	// Storage, kept without reset
	always_ff @(posedge ref_clk_i) begin
		if (push) begin
			mem[wr_ptr] <= in_data_i;
		end
	end

	// State registers
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count_o <= '0;
			in_ready_o <= 1'b1;
			out_valid_o <= 1'b0;
			out_data_o <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count_o <= next_count;
			in_ready_o <= next_in_ready;
			out_valid_o <= next_out_valid;
			out_data_o <= next_out_data;
		end
	end
endmodule // sync_fifo

// File: tb_uart_regmap.sv
/* Self-checking bench for the register map and FIFO control.
   Assumes host_bus_model and the checker are compiled alongside. */
`timescale 1ns/10ps
module tb_uart_regmap;
	import uart_regmap_pkg::*;
	logic clk, rst_n, cs_n, rd_n, wr_n, oe, rx_valid, rx_ready, tx_valid;
	logic tx_ready, fen, hit, rrdy, trdy;
	logic [2:0] addr;
	logic [7:0] wdata, rdata, tx_byte, lcfg;
	logic [5:0] mctl;
	logic [15:0] baud;
	rx_word_s rx_word;
	int fail_count = 0;
	int checks_done = 0;
	logic [4:0] lv [4] = '{5'h01, 5'h04, 5'h08, 5'h0e};

	host_bus_model host (.ref_clk_i(clk), .rdata_i(rdata), .cs_n_o(cs_n),
		.rd_n_o(rd_n), .wr_n_o(wr_n), .addr_o(addr), .wdata_o(wdata));
	uart_regmap #(.DEPTH(16)) uut (.ref_clk_i(clk), .reset_n_i(rst_n),
		.cs_n_i(cs_n), .rd_n_i(rd_n), .wr_n_i(wr_n), .addr_i(addr),
		.data_i(wdata), .data_o(rdata), .data_oe_o(oe),
		.rx_char_valid_i(rx_valid), .rx_char_i(rx_word),
		.rx_char_ready_o(rx_ready), .tx_char_valid_o(tx_valid),
		.tx_char_o(tx_byte), .tx_char_ready_i(tx_ready),
		.tx_shift_empty_i(1'b1), .modem_status_i(8'h00),
		.baud_divisor_o(baud), .line_configuration_o(lcfg),
		.modem_control_o(mctl), .fifo_enabled_o(fen),
		.rx_trigger_hit_o(hit), .receive_ready_out_o(rrdy),
		.transmit_ready_out_o(trdy));

	// Clock
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	task automatic check(input string w, input logic [15:0] s, e);
		checks_done++;
		if (s !== e) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.access(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [2:0] a, input logic [7:0] e, string w);
		logic [7:0] q;
		host.access(1'b0, a, 8'h00, q);
		check(w, {8'h00, q}, {8'h00, e});
	endtask
	// Offer one received word and wait for it to be taken
	task automatic push(input logic [10:0] w);
		int n;
		@(negedge clk);
		rx_valid = 1'b1;
		rx_word = w;
		for (n = 0; n < 200 && rx_ready !== 1'b1; n++)
			@(negedge clk);
		@(negedge clk);
		rx_valid = 1'b0;
	endtask
	task automatic t_reset;
		rd(3'h5, 8'h60, "line status");
		rd(3'h2, 8'h01, "identity");
		check("tx ready", trdy, 1'b1);
		$display("test reset done");
	endtask
	task automatic t_divisor;
		wr(3'h3, 8'h80);
		wr(3'h0, 8'h34);
		wr(3'h1, 8'h12);
		check("divisor", baud, 16'h1234);
		rd(3'h1, 8'h12, "divisor high");
		wr(3'h3, 8'h03);
		check("line cfg", lcfg, 8'h03);
		wr(3'h1, 8'hff);
		rd(3'h1, 8'h0f, "enables");
		wr(3'h1, 8'h00);
		wr(3'h7, 8'ha5);
		rd(3'h7, 8'ha5, "scratch");
		wr(3'h4, 8'hff);
		check("modem ctl", mctl, 6'h3f);
		$display("test divisor done");
	endtask
	task automatic t_fifo_ctl;
		wr(3'h2, 8'hc8);
		check("enable kept", fen, 1'b0);
		rd(3'h2, 8'h01, "single identity");
		wr(3'h2, 8'h41);
		check("enabled", fen, 1'b1);
		rd(3'h2, 8'hc1, "fifo identity");
		$display("test fifo control done");
	endtask
	// Every trigger code: one short of level, level, then rx flush
	task automatic t_trigger;
		int c, i;
		for (c = 0; c < 4; c++) begin
			wr(3'h2, {c[1:0], 6'h01});
			for (i = 0; i < lv[c] - 1; i++)
				push(8'(i));
			repeat (3) @(negedge clk);
			check("below level", hit, 1'b0);
			push(8'hee);
			repeat (3) @(negedge clk);
			check("at level", hit, 1'b1);
			wr(3'h2, {c[1:0], 6'h03});
			check("rx flushed", {hit, rrdy}, 2'h0);
		end
		$display("test trigger done");
	endtask
	task automatic t_tx;
		wr(3'h0, 8'h11);
		wr(3'h0, 8'h22);
		check("tx head", {tx_valid, tx_byte}, 9'h111);
		check("tx ready m0", trdy, 1'b0);
		wr(3'h2, 8'h05);
		check("tx flushed", {tx_valid, trdy}, 2'h1);
		wr(3'h0, 8'h33);
		wr(3'h2, 8'h00);
		check("off flush", {tx_valid, fen}, 2'h0);
		rd(3'h2, 8'h01, "off identity");
		@(negedge clk);
		tx_ready = 1'b1;
		wr(3'h0, 8'h44);
		check("tx drained", tx_valid, 1'b0);
		$display("test transmit done");
	endtask
	// Mode 1 ready pins: tx full, rx trigger hit held until empty
	task automatic t_mode;
		int i;
		@(negedge clk);
		tx_ready = 1'b0;
		wr(3'h2, 8'h01);
		wr(3'h2, 8'h79); // Reserved bits 4 and 5 set
		wr(3'h0, 8'h55);
		check("tx ready m1", trdy, 1'b1);
		for (i = 0; i < 15; i++)
			wr(3'h0, 8'(i));
		check("tx full m1", trdy, 1'b0);
		push(11'h166);
		repeat (3) @(negedge clk);
		check("rx ready m1", rrdy, 1'b0);
		rd(3'h5, 8'h85, "fifo status");
		for (i = 0; i < 3; i++)
			push(11'(i));
		repeat (3) @(negedge clk);
		check("rx ready hit", rrdy, 1'b1);
		rd(3'h0, 8'h66, "rx data");
		check("rx ready held", rrdy, 1'b1);
		wr(3'h2, 8'h41);
		check("ready m0", {rrdy, trdy}, 2'h2);
		$display("test ready mode done");
	endtask
	// Single mode: depth one, FIFO error bit masked
	task automatic t_single;
		wr(3'h2, 8'h00);
		push(11'h13c);
		repeat (2) @(negedge clk);
		check("single full", rx_ready, 1'b0);
		rd(3'h5, 8'h65, "single status");
		rd(3'h0, 8'h3c, "single data");
		$display("test single done");
	endtask
	// Reset in mid-run clears programmed state
	task automatic t_mid_reset;
		wr(3'h1, 8'h05);
		wr(3'h2, 8'h01);
		@(negedge clk);
		rst_n = 1'b0;
		repeat (4) @(negedge clk);
		rst_n = 1'b1;
		check("reset cfg", {fen, lcfg}, 9'h000);
		rd(3'h1, 8'h00, "enables reset");
		t_reset();
	endtask
	// Hang guard
	initial begin
		repeat (40000) @(posedge clk);
		fail_count++;
		test_done();
	end
	// Main sequence
	initial begin
		rst_n = 1'b0;
		rx_valid = 1'b0;
		rx_word = '0;
		tx_ready = 1'b0;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		t_reset();
		t_divisor();
		t_fifo_ctl();
		t_trigger();
		t_tx();
		t_mode();
		t_single();
		t_mid_reset();
		test_done();
	end
endmodule // tb_uart_regmap

// File: uart_regmap.sv
/*
 * Register map and FIFO control of the serial element: host pin decode,
 * divisor selection, FIFO control, identity and line status, ready pins.
 * Assumes the framing logic feeds received words and drains transmit words
 * on the same clock; host pins are asynchronous and synchronised here.
 */
`timescale 1ns/10ps
`include "uart_regmap_defs.svh"
module uart_regmap import uart_regmap_pkg::*; #(
	parameter int DEPTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic [2:0] addr_i,
	input wire logic [7:0] data_i,
	output logic [7:0] data_o,
	output logic data_oe_o,
	input wire logic rx_char_valid_i,
	input wire rx_word_s rx_char_i,
	output logic rx_char_ready_o,
	output logic tx_char_valid_o,
	output logic [7:0] tx_char_o,
	input wire logic tx_char_ready_i,
	input wire logic tx_shift_empty_i,
	input wire logic [7:0] modem_status_i,
	output logic [15:0] baud_divisor_o,
	output logic [7:0] line_configuration_o,
	output logic [5:0] modem_control_o,
	output logic fifo_enabled_o,
	output logic rx_trigger_hit_o,
	output logic receive_ready_out_o,
	output logic transmit_ready_out_o
);
	localparam int CW = $clog2(DEPTH + 1);

	host_pins_s pins_meta, pins, raw_pins;
	logic sel_rd_d, sel_wr_d, rd_pulse, wr_pulse, div_access;
	fifo_ctl_s fifo_ctl, next_fifo_ctl;
	logic rx_flush, tx_flush;
	logic [3:0] interrupt_enables, next_interrupt_enables;
	logic [7:0] next_line_configuration, scratch, next_scratch;
	logic [5:0] next_modem_control;
	logic [15:0] next_baud_divisor;
	logic [7:0] line_status, next_line_status, interrupt_identity, rd_mux;
	logic [7:0] next_data_o;
	logic overrun, next_overrun, rx_err_seen, next_rx_err_seen;
	logic thre_pend, next_thre_pend, tx_empty_d;
	logic next_trig_hit, next_rx_ready_out, next_tx_ready_out;
	logic [CW-1:0] rx_count, trig_level;
	logic rx_valid, rx_pop, tx_in_ready, thr_wr, single;
	rx_word_s rx_head;
	logic [CW-1:0] tx_count;

	// Host pins pass two flip-flops before any decode reads them
	always_comb begin
		raw_pins.sel = ~cs_n_i;
		raw_pins.rd = ~rd_n_i;
		raw_pins.wr = ~wr_n_i;
		raw_pins.addr = addr_i;
		raw_pins.data = data_i;
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pins_meta <= '0;
			pins <= '0;
			sel_rd_d <= 1'b0;
			sel_wr_d <= 1'b0;
		end else begin
			pins_meta <= raw_pins;
			pins <= pins_meta;
			sel_rd_d <= pins.sel & pins.rd;
			sel_wr_d <= pins.sel & pins.wr;
		end
	end

	// Access starts on the leading edge of a selected strobe
	always_comb begin
		rd_pulse = pins.sel & pins.rd & ~sel_rd_d;
		wr_pulse = pins.sel & pins.wr & ~sel_wr_d;
		div_access = line_configuration_o[`LCFG_DIV_ACCESS];
		single = ~fifo_ctl.enable;
		rx_pop = rd_pulse & ~div_access & (pins.addr == `ADDR_DATA);
		thr_wr = wr_pulse & ~div_access & (pins.addr == `ADDR_DATA);
	end

	// Writable registers and FIFO control
	always_comb begin
		next_fifo_ctl = fifo_ctl;
		next_interrupt_enables = interrupt_enables;
		next_line_configuration = line_configuration_o;
		next_modem_control = modem_control_o;
		next_baud_divisor = baud_divisor_o;
		next_scratch = scratch;
		rx_flush = 1'b0;
		tx_flush = 1'b0;
		if (wr_pulse) begin
			case (pins.addr)
				`ADDR_DATA: begin
					if (div_access) begin
						next_baud_divisor[7:0] = pins.data;
					end
				end
				`ADDR_ENABLES: begin
					if (div_access) begin
						next_baud_divisor[15:8] = pins.data;
					end else begin
						next_interrupt_enables = pins.data[3:0];
					end
				end
				`ADDR_IDENT: begin
					// Identity is read-only; this write lands in FIFO control
					next_fifo_ctl.enable = pins.data[`FCTL_ENABLE];
					if (pins.data[`FCTL_ENABLE] != fifo_ctl.enable) begin
						rx_flush = 1'b1;
						tx_flush = 1'b1;
					end
					// Bits 4 and 5 have no function
					if (pins.data[`FCTL_ENABLE]) begin
						next_fifo_ctl.ready_mode = pins.data[`FCTL_READY_MODE];
						next_fifo_ctl.trigger =
							pins.data[`FCTL_TRIG_HI:`FCTL_TRIG_LO];
						if (pins.data[`FCTL_RX_FLUSH]) begin
							rx_flush = 1'b1;
						end
						if (pins.data[`FCTL_TX_FLUSH]) begin
							tx_flush = 1'b1;
						end
					end
				end
				`ADDR_LINE_CFG: begin
					next_line_configuration = pins.data;
				end
				`ADDR_MODEM_CTL: begin
					next_modem_control = pins.data[5:0];
				end
				`ADDR_SCRATCH: begin
					next_scratch = pins.data;
				end
				default: begin
					next_scratch = scratch;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			fifo_ctl <= '0;
			interrupt_enables <= '0;
			line_configuration_o <= `RST_BYTE;
			modem_control_o <= '0;
			baud_divisor_o <= `RST_DIVISOR;
			scratch <= `RST_BYTE;
		end else begin
			fifo_ctl <= next_fifo_ctl;
			interrupt_enables <= next_interrupt_enables;
			line_configuration_o <= next_line_configuration;
			modem_control_o <= next_modem_control;
			baud_divisor_o <= next_baud_divisor;
			scratch <= next_scratch;
		end
	end

	// Receive FIFO; bit 0 of each word is the first bit on the line
	sync_fifo #(
		.WIDTH($bits(rx_word_s)),
		.DEPTH(DEPTH)
	) rx_fifo (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.flush_i(rx_flush),
		.single_i(single),
		.in_valid_i(rx_char_valid_i),
		.in_data_i(rx_char_i),
		.in_ready_o(rx_char_ready_o),
		.out_valid_o(rx_valid),
		.out_data_o(rx_head),
		.out_ready_i(rx_pop),
		.count_o(rx_count)
	);

	// Transmit FIFO, drained by the transmit shift logic
	sync_fifo #(
		.WIDTH(8),
		.DEPTH(DEPTH)
	) tx_fifo (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.flush_i(tx_flush),
		.single_i(single),
		.in_valid_i(thr_wr),
		.in_data_i(pins.data),
		.in_ready_o(tx_in_ready),
		.out_valid_o(tx_char_valid_o),
		.out_data_o(tx_char_o),
		.out_ready_i(tx_char_ready_i),
		.count_o(tx_count)
	);

	// Status flags; a new event wins over a clearing read
	always_comb begin
		next_overrun = overrun;
		next_rx_err_seen = rx_err_seen;
		next_thre_pend = thre_pend;
		if (rd_pulse && pins.addr == `ADDR_LINE_STAT) begin
			next_overrun = 1'b0;
			next_rx_err_seen = 1'b0;
		end
		if (rx_char_valid_i && !rx_char_ready_o) begin
			next_overrun = 1'b1;
		end
		if (rx_char_valid_i && rx_char_ready_o &&
			(rx_char_i.brk | rx_char_i.frame_err | rx_char_i.parity_err)) begin
			next_rx_err_seen = 1'b1;
		end
		if (thr_wr || (rd_pulse && pins.addr == `ADDR_IDENT &&
			interrupt_identity[3:0] == `IDENT_TX_EMPTY)) begin
			next_thre_pend = 1'b0;
		end
		if (!tx_char_valid_o && !tx_empty_d) begin
			next_thre_pend = 1'b1;
		end
		next_line_status = {fifo_ctl.enable & rx_err_seen,
			~tx_char_valid_o & tx_shift_empty_i, ~tx_char_valid_o,
			rx_valid & rx_head.brk, rx_valid & rx_head.frame_err,
			rx_valid & rx_head.parity_err, overrun, rx_valid};
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			overrun <= 1'b0;
			rx_err_seen <= 1'b0;
			thre_pend <= 1'b0;
			tx_empty_d <= 1'b1;
			line_status <= `RST_LINE_STAT;
		end else begin
			overrun <= next_overrun;
			rx_err_seen <= next_rx_err_seen;
			thre_pend <= next_thre_pend;
			tx_empty_d <= ~tx_char_valid_o;
			line_status <= next_line_status;
		end
	end

	// Identity: highest pending source, FIFO mode marks in bits 7:6
	always_comb begin
		interrupt_identity = {{2{fifo_ctl.enable}}, 2'b00, `IDENT_NONE};
		if (interrupt_enables[`IEN_LINE_STAT] && |line_status[4:1]) begin
			interrupt_identity[3:0] = `IDENT_LINE;
		end else if (interrupt_enables[`IEN_RX_DATA] &&
			(fifo_ctl.enable ? rx_trigger_hit_o : rx_valid)) begin
			interrupt_identity[3:0] = `IDENT_RX_DATA;
		end else if (interrupt_enables[`IEN_TX_EMPTY] && thre_pend) begin
			interrupt_identity[3:0] = `IDENT_TX_EMPTY;
		end else if (interrupt_enables[`IEN_MODEM] && |modem_status_i[3:0]) begin
			interrupt_identity[3:0] = `IDENT_MODEM;
		end
	end

	// Read data; FIFO control itself never reaches the bus
	always_comb begin
		case (pins.addr)
			`ADDR_DATA: rd_mux = div_access ? baud_divisor_o[7:0] : rx_head.data;
			`ADDR_ENABLES: rd_mux = div_access ? baud_divisor_o[15:8] :
				{4'h0, interrupt_enables};
			`ADDR_IDENT: rd_mux = interrupt_identity;
			`ADDR_LINE_CFG: rd_mux = line_configuration_o;
			`ADDR_MODEM_CTL: rd_mux = {2'b00, modem_control_o};
			`ADDR_LINE_STAT: rd_mux = line_status;
			`ADDR_MODEM_STAT: rd_mux = modem_status_i;
			`ADDR_SCRATCH: rd_mux = scratch;
			default: rd_mux = 8'h00;
		endcase
		next_data_o = rd_pulse ? rd_mux : data_o;
	end

	// Trigger compare and ready pins
	always_comb begin
		case (fifo_ctl.trigger)
			2'b00: trig_level = CW'(`TRIG_LVL_0);
			2'b01: trig_level = CW'(`TRIG_LVL_1);
			2'b10: trig_level = CW'(`TRIG_LVL_2);
			default: trig_level = CW'(`TRIG_LVL_3);
		endcase
		next_trig_hit = fifo_ctl.enable & (rx_count >= trig_level);
		if (fifo_ctl.enable && fifo_ctl.ready_mode) begin
			next_rx_ready_out = rx_trigger_hit_o |
				(receive_ready_out_o & rx_valid);
			next_tx_ready_out = tx_in_ready;
		end else begin
			next_rx_ready_out = rx_valid;
			next_tx_ready_out = (tx_count == '0);
		end
	end

	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			data_o <= 8'h00;
			data_oe_o <= 1'b0;
			fifo_enabled_o <= 1'b0;
			rx_trigger_hit_o <= 1'b0;
			receive_ready_out_o <= 1'b0;
			transmit_ready_out_o <= 1'b1;
		end else begin
			data_o <= next_data_o;
			data_oe_o <= pins.sel & pins.rd;
			fifo_enabled_o <= next_fifo_ctl.enable;
			rx_trigger_hit_o <= next_trig_hit;
			receive_ready_out_o <= next_rx_ready_out;
			transmit_ready_out_o <= next_tx_ready_out;
		end
	end
endmodule // uart_regmap

// File: uart_regmap_checker.sv
/* Port assertions for the serial element register map.
   Assumes binding onto uart_regmap, one clock, active-low reset. */
`timescale 1ns/10ps
module uart_regmap_checker #(
	parameter int DEPTH = 16
) (
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic cs_n_i,
	input wire logic rd_n_i,
	input wire logic wr_n_i,
	input wire logic data_oe_o,
	input wire logic rx_char_valid_i,
	input wire logic rx_char_ready_o,
	input wire logic tx_char_valid_o,
	input wire logic [7:0] tx_char_o,
	input wire logic tx_char_ready_i,
	input wire logic [15:0] baud_divisor_o,
	input wire logic [7:0] line_configuration_o,
	input wire logic fifo_enabled_o,
	input wire logic rx_trigger_hit_o,
	input wire logic receive_ready_out_o,
	input wire logic transmit_ready_out_o
);
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!reset_n_i);
	// Read strobe held low for four edges, or idle for six
	sequence s_rd_low;
		(!cs_n_i && !rd_n_i) [*4];
	endsequence
	sequence s_rd_idle;
		rd_n_i [*6];
	endsequence
	property p_oe_on;
		s_rd_low |-> data_oe_o;
	endproperty
	a_oe_on: assert property (p_oe_on) else $error("no read drive");
	property p_oe_off;
		s_rd_idle |-> !data_oe_o;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("stray drive");
	// Configuration only moves after a host write
	property p_cfg_write;
		!$stable({baud_divisor_o, line_configuration_o, fifo_enabled_o})
			|-> $past(!cs_n_i && !wr_n_i, 2);
	endproperty
	a_cfg_write: assert property (p_cfg_write)
		else $error("cfg moved");
	property p_trig_en;
		rx_trigger_hit_o |-> $past(fifo_enabled_o);
	endproperty
	a_trig_en: assert property (p_trig_en) else $error("hit unarmed");
	property p_tx_ready;
		(!tx_char_valid_o) [*3] |-> transmit_ready_out_o;
	endproperty
	a_tx_ready: assert property (p_tx_ready)
		else $error("tx not ready");
	property p_tx_hold;
		tx_char_valid_o && !tx_char_ready_i && wr_n_i && $past(wr_n_i)
			&& $past(wr_n_i, 2) |=> tx_char_valid_o && $stable(tx_char_o);
	endproperty
	a_tx_hold: assert property (p_tx_hold) else $error("tx head lost");
	property p_rx_single;
		!fifo_enabled_o && rx_char_valid_i && rx_char_ready_o && rd_n_i
			&& $past(rd_n_i) && $past(rd_n_i, 2) && wr_n_i && $past(wr_n_i)
			&& $past(wr_n_i, 2) |=> !rx_char_ready_o;
	endproperty
	a_rx_single: assert property (p_rx_single)
		else $error("depth not 1");
	property p_reset_vals;
		$rose(reset_n_i) |-> line_configuration_o == 8'h00 && !fifo_enabled_o
			&& transmit_ready_out_o && !receive_ready_out_o;
	endproperty
	a_reset_vals: assert property (p_reset_vals)
		else $error("reset state");
endmodule // uart_regmap_checker

bind uart_regmap uart_regmap_checker #(.DEPTH(DEPTH)) u_checker (
	.ref_clk_i, .reset_n_i, .cs_n_i, .rd_n_i, .wr_n_i, .data_oe_o,
	.rx_char_valid_i, .rx_char_ready_o, .tx_char_valid_o, .tx_char_o,
	.tx_char_ready_i, .baud_divisor_o, .line_configuration_o,
	.fifo_enabled_o, .rx_trigger_hit_o, .receive_ready_out_o,
	.transmit_ready_out_o
);

// File: uart_regmap_defs.svh
/*
 * Register offsets, field positions, reset values and trigger levels of the
 * serial element register map with FIFO control.
 * Assumes inclusion by bare name from the package and the design modules.
 */
// Behaviour
// - Locations 0..7; 0 and 1 reach divisor bytes while access bit set.
// - Divisor access select is the top bit of line configuration.
// - Location 2 reads identity, writes FIFO control; control unreadable.
// - Enable bit one turns on both 16-entry FIFOs; zero: single-character.
// - Other FIFO control bits ignored unless the same write sets bit 0.
// - Changing the FIFO enable bit flushes both FIFOs.
// - Bit 1 empties receive FIFO and count, self-clears; shifter kept.
// - Bit 2 empties transmit FIFO and count, self-clears; shifter kept.
// - With FIFOs enabled, bit 3 moves both ready outputs to mode 1.
// - Bits 7:6 pick receive trigger: 1, 4, 8 or 14 bytes.
// - Bits 4 and 5 are reserved and have no function.
// - Data bit 0 is least significant, first shifted out and in.
// - Single-character mode reads zero: timeout, FIFOs-enabled, FIFO error.
// - Identity bits 7:6 set while FIFO enable is set, else clear.
// - Reset clears FIFO control, line config and enables; status 0x60.
`ifndef UART_REGMAP_DEFS_SVH
`define UART_REGMAP_DEFS_SVH

// Register locations
`define ADDR_DATA 3'h0
`define ADDR_ENABLES 3'h1
`define ADDR_IDENT 3'h2
`define ADDR_LINE_CFG 3'h3
`define ADDR_MODEM_CTL 3'h4
`define ADDR_LINE_STAT 3'h5
`define ADDR_MODEM_STAT 3'h6
`define ADDR_SCRATCH 3'h7

// Field positions
`define LCFG_DIV_ACCESS 7
`define FCTL_ENABLE 0
`define FCTL_RX_FLUSH 1
`define FCTL_TX_FLUSH 2
`define FCTL_READY_MODE 3
`define FCTL_TRIG_LO 6
`define FCTL_TRIG_HI 7
`define IEN_RX_DATA 0
`define IEN_TX_EMPTY 1
`define IEN_LINE_STAT 2
`define IEN_MODEM 3

// Reset values
`define RST_LINE_STAT 8'h60
`define RST_BYTE 8'h00
`define RST_DIVISOR 16'h0000

// Identity codes in bits 3:0
`define IDENT_NONE 4'h1
`define IDENT_LINE 4'h6
`define IDENT_RX_DATA 4'h4
`define IDENT_TX_EMPTY 4'h2
`define IDENT_MODEM 4'h0

// Receive trigger levels in bytes
`define TRIG_LVL_0 5'h01
`define TRIG_LVL_1 5'h04
`define TRIG_LVL_2 5'h08
`define TRIG_LVL_3 5'h0e

`endif

// File: uart_regmap_pkg.sv
/*
 * Types shared by the register map and its FIFOs.
 * Assumes the defines header sits in the include path.
 */
package uart_regmap_pkg;

	// One received character with its error flags
	typedef struct packed {
		logic brk;
		logic frame_err;
		logic parity_err;
		logic [7:0] data;
	} rx_word_s;

	// Host bus pins after synchronisation, active high
	typedef struct packed {
		logic sel;
		logic rd;
		logic wr;
		logic [2:0] addr;
		logic [7:0] data;
	} host_pins_s;

	// Programmed FIFO control state
	typedef struct packed {
		logic enable;
		logic ready_mode;
		logic [1:0] trigger;
	} fifo_ctl_s;

endpackage
